//--- verilog/slcfg_pkg.sv
package slcfg_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          SLCFG_AW          = 8;
  localparam int          SLCFG_DW          = 8;
  localparam logic [7:0]  SLCFG_OFS_OWN     = 8'h00;
  localparam logic [7:0]  SLCFG_OFS_REMOTE  = 8'h01;
  localparam logic [7:0]  SLCFG_OFS_SPREAD  = 8'h02;
  localparam logic [7:0]  SLCFG_OFS_CAL     = 8'h03;
  localparam logic [7:0]  SLCFG_LOCK_LAST   = 8'h1F;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SLCFG_ADDR_LSB   = 1;
  localparam int SLCFG_LOCK_BIT   = 0;
  localparam int SLCFG_SPREAD_LSB = 5;
  localparam int SLCFG_AUDIO_BIT  = 4;
  localparam int SLCFG_PIX_LSB    = 2;
  localparam int SLCFG_SER_LSB    = 0;
  localparam int SLCFG_RECAL_LSB  = 6;
  localparam int SLCFG_SAWTOOTH_DIVIDER_LSB   = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [6:0] SLCFG_OWN_RST    = 7'h40;
  localparam logic [6:0] SLCFG_REMOTE_RST = 7'h48;
  localparam logic [2:0] SLCFG_SPREAD_OFF = 3'h0;
  localparam logic [2:0] SLCFG_SPREAD_LOW = 3'h1;
  localparam logic [1:0] SLCFG_RANGE_AUTO = 2'h3;
  localparam logic [1:0] SLCFG_RECAL_ONCE = 2'h0;
  localparam logic [5:0] SLCFG_SAWTOOTH_DIVIDER_AUTO  = 6'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SLCFG_CLK_PERIOD_NS = 25;
  localparam int SLCFG_RECAL_A_MS    = 2;
  localparam int SLCFG_RECAL_B_MS    = 16;
  localparam int SLCFG_RECAL_C_MS    = 256;
  localparam int SLCFG_CNT_W         = 24;
  localparam int SLCFG_RECAL_A_CYC   = SLCFG_RECAL_A_MS * 1000000 / SLCFG_CLK_PERIOD_NS;
  localparam int SLCFG_RECAL_B_CYC   = SLCFG_RECAL_B_MS * 1000000 / SLCFG_CLK_PERIOD_NS;
  localparam int SLCFG_RECAL_C_CYC   = SLCFG_RECAL_C_MS * 1000000 / SLCFG_CLK_PERIOD_NS;

  // ****************************************************************
  // configuration carrier
  // ****************************************************************
  typedef struct packed {
    logic [6:0] own_address_field;
    logic       config_lock_bit;
    logic [6:0] remote_address_field;
    logic [2:0] spread;
    logic       audio_channel_enable;
    logic [1:0] pixel_clock_range;
    logic [1:0] serial_rate_range;
    logic [1:0] spread_recalibration_interval;
    logic [5:0] sawtooth_divider;
  } slcfg_cfg_t;

endpackage

//--- verilog/slcfg_regs.sv
module slcfg_regs
  import slcfg_pkg::*;
#(
  parameter int RECAL_A_CYC = SLCFG_RECAL_A_CYC,
  parameter int RECAL_B_CYC = SLCFG_RECAL_B_CYC,
  parameter int RECAL_C_CYC = SLCFG_RECAL_C_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [SLCFG_AW-1:0] addr,
  input  wire logic [SLCFG_DW-1:0] wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  input  wire logic [1:0]          configuration_pins,
  input  wire logic                link_locked,
  output logic      [SLCFG_DW-1:0] rdata_r,
  output slcfg_cfg_t               cfg_r,
  output logic                     spread_on_r,
  output logic                     sawtooth_divider_manual_r,
  output logic                     recal_pulse_r
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (RECAL_A_CYC < 1 || RECAL_B_CYC < 1 || RECAL_C_CYC < 1 ||
      RECAL_A_CYC >= (1 << SLCFG_CNT_W) || RECAL_B_CYC >= (1 << SLCFG_CNT_W) ||
      RECAL_C_CYC >= (1 << SLCFG_CNT_W)) begin : g_bad_recal
    $error("recalibration periods must lie in 1 .. 2**24-1");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic spread_active(input logic [2:0] code);
    spread_active = (code[1:0] != 2'h0);
  endfunction

  function automatic logic [SLCFG_DW-1:0] reg_read(input logic [SLCFG_AW-1:0] a,
                                                   input slcfg_cfg_t c);
    case (a)
      SLCFG_OFS_OWN:    reg_read = {c.own_address_field, c.config_lock_bit};
      SLCFG_OFS_REMOTE: reg_read = {c.remote_address_field, 1'b0};
      SLCFG_OFS_SPREAD: reg_read = {c.spread, c.audio_channel_enable,
                                    c.pixel_clock_range, c.serial_rate_range};
      SLCFG_OFS_CAL:    reg_read = {c.spread_recalibration_interval, c.sawtooth_divider};
      default:          reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic [SLCFG_CNT_W-1:0] recal_period(input logic [1:0] sel);
    case (sel)
      2'h1:    recal_period = SLCFG_CNT_W'(RECAL_A_CYC);
      2'h2:    recal_period = SLCFG_CNT_W'(RECAL_B_CYC);
      2'h3:    recal_period = SLCFG_CNT_W'(RECAL_C_CYC);
      default: recal_period = SLCFG_CNT_W'(1);
    endcase
  endfunction

  // ****************************************************************
  // write path
  // ****************************************************************
  logic       strap_done_r;
  logic       wr_ok;
  slcfg_cfg_t cfg_nxt;

  // the lock range covers every register here, so once set only reset clears it
  assign wr_ok = wr && !cfg_r.config_lock_bit && (addr <= SLCFG_LOCK_LAST);

  always_comb begin
    cfg_nxt = cfg_r;
    if (!strap_done_r) begin
      cfg_nxt.spread = configuration_pins[0] ? SLCFG_SPREAD_LOW : SLCFG_SPREAD_OFF;
    end
    if (wr_ok) begin
      case (addr)
        SLCFG_OFS_OWN: begin
          cfg_nxt.own_address_field = wdata[7:SLCFG_ADDR_LSB];
          cfg_nxt.config_lock_bit   = wdata[SLCFG_LOCK_BIT];
        end
        SLCFG_OFS_REMOTE: begin
          cfg_nxt.remote_address_field = wdata[7:SLCFG_ADDR_LSB];
        end
        SLCFG_OFS_SPREAD: begin
          cfg_nxt.spread               = wdata[7:SLCFG_SPREAD_LSB];
          cfg_nxt.audio_channel_enable = wdata[SLCFG_AUDIO_BIT];
          cfg_nxt.pixel_clock_range    = wdata[SLCFG_PIX_LSB+:2];
          cfg_nxt.serial_rate_range    = wdata[SLCFG_SER_LSB+:2];
        end
        SLCFG_OFS_CAL: begin
          cfg_nxt.spread_recalibration_interval = wdata[SLCFG_RECAL_LSB+:2];
          cfg_nxt.sawtooth_divider              = wdata[SLCFG_SAWTOOTH_DIVIDER_LSB+:6];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r.own_address_field             <= SLCFG_OWN_RST;
      cfg_r.config_lock_bit               <= 1'b0;
      cfg_r.remote_address_field          <= SLCFG_REMOTE_RST;
      cfg_r.spread                        <= SLCFG_SPREAD_OFF;
      cfg_r.audio_channel_enable          <= 1'b1;
      cfg_r.pixel_clock_range             <= SLCFG_RANGE_AUTO;
      cfg_r.serial_rate_range             <= SLCFG_RANGE_AUTO;
      cfg_r.spread_recalibration_interval <= SLCFG_RECAL_ONCE;
      cfg_r.sawtooth_divider              <= SLCFG_SAWTOOTH_DIVIDER_AUTO;
      spread_on_r                         <= 1'b0;
      sawtooth_divider_manual_r                       <= 1'b0;
    end else begin
      cfg_r         <= cfg_nxt;
      spread_on_r   <= spread_active(cfg_nxt.spread);
      sawtooth_divider_manual_r <= (cfg_nxt.sawtooth_divider != SLCFG_SAWTOOTH_DIVIDER_AUTO);
    end
  end

  // pins are caught on the first edge after release, never under the async reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      rdata_r <= reg_read(addr, cfg_r);
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ****************************************************************
  // spread recalibration timer
  // ****************************************************************
  logic                   lock_d_r;
  logic [SLCFG_CNT_W-1:0] cnt_r;
  logic                   lock_rise;

  assign lock_rise = link_locked && !lock_d_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_d_r <= 1'b0;
    end else begin
      lock_d_r <= link_locked;
    end
  end

  // a shortened interval restarts at once via >=, no wait for counter wrap
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r         <= '0;
      recal_pulse_r <= 1'b0;
    end else if (!link_locked) begin
      cnt_r         <= '0;
      recal_pulse_r <= 1'b0;
    end else if (lock_rise) begin
      cnt_r         <= '0;
      recal_pulse_r <= 1'b1;
    end else if (cfg_r.spread_recalibration_interval == SLCFG_RECAL_ONCE) begin
      cnt_r         <= '0;
      recal_pulse_r <= 1'b0;
    end else if (cnt_r >= recal_period(cfg_r.spread_recalibration_interval) - SLCFG_CNT_W'(1)) begin
      cnt_r         <= '0;
      recal_pulse_r <= 1'b1;
    end else begin
      cnt_r         <= cnt_r + SLCFG_CNT_W'(1);
      recal_pulse_r <= 1'b0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  own_addr_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_OWN
    |=> cfg_r.own_address_field == $past(wdata[7:1]) && cfg_r.config_lock_bit == $past(wdata[0]))
    else $error("own address write not taken");

  lock_blocks_a: assert property (
    wr && cfg_r.config_lock_bit && strap_done_r |=> cfg_r == $past(cfg_r))
    else $error("write changed a locked register");

  spread_decode_a: assert property (
    spread_on_r == (cfg_r.spread[1:0] != 2'h0))
    else $error("spread active flag wrong");

  strap_load_a: assert property (
    $rose(strap_done_r) |-> cfg_r.spread == {2'b00, $past(configuration_pins[0])})
    else $error("spread not loaded from pins");

  audio_read_a: assert property (
    rd && addr == SLCFG_OFS_SPREAD |=> rdata_r[4] == $past(cfg_r.audio_channel_enable))
    else $error("audio enable readback wrong");

  ranges_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_SPREAD
    |=> cfg_r.pixel_clock_range == $past(wdata[3:2]) && cfg_r.serial_rate_range == $past(wdata[1:0]))
    else $error("range fields not written");

  recal_rise_a: assert property (
    link_locked && !lock_d_r |=> recal_pulse_r)
    else $error("no calibration after lock");

  recal_once_a: assert property (
    link_locked && lock_d_r && cfg_r.spread_recalibration_interval == 2'h0 |=> !recal_pulse_r)
    else $error("repeat calibration in once mode");

  sawtooth_divider_mode_a: assert property (
    sawtooth_divider_manual_r == (cfg_r.sawtooth_divider != 6'h00))
    else $error("sawtooth divider mode wrong");

  reserved_zero_a: assert property (
    rd && addr == SLCFG_OFS_REMOTE |=> rdata_r[0] == 1'b0)
    else $error("reserved bit reads one");

  read_idle_a: assert property (
    !rd |=> rdata_r == 8'h00)
    else $error("read data outside read slot");

  own_read_a: assert property (
    rd && addr == SLCFG_OFS_OWN
    |=> rdata_r == {$past(cfg_r.own_address_field), $past(cfg_r.config_lock_bit)})
    else $error("own address readback wrong");

  remote_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_REMOTE
    |=> cfg_r.remote_address_field == $past(wdata[7:1]))
    else $error("remote address write not taken");

  remote_read_a: assert property (
    rd && addr == SLCFG_OFS_REMOTE |=> rdata_r[7:1] == $past(cfg_r.remote_address_field))
    else $error("remote address readback wrong");

  // the lock bit lies inside its own read-only range, so only reset can drop it
  lock_sticky_a: assert property (
    cfg_r.config_lock_bit |=> cfg_r.config_lock_bit)
    else $error("lock bit dropped without reset");

  // on the first edge after reset a software write overrides the strap value
  spread_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_SPREAD && strap_done_r
    |=> cfg_r.spread == $past(wdata[7:5]))
    else $error("spread field write not taken");

  audio_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_SPREAD |=> cfg_r.audio_channel_enable == $past(wdata[4]))
    else $error("audio enable write not taken");

  pixel_read_a: assert property (
    rd && addr == SLCFG_OFS_SPREAD |=> rdata_r[3:2] == $past(cfg_r.pixel_clock_range))
    else $error("pixel clock range readback wrong");

  rate_read_a: assert property (
    rd && addr == SLCFG_OFS_SPREAD |=> rdata_r[1:0] == $past(cfg_r.serial_rate_range))
    else $error("serial rate range readback wrong");

  recal_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_CAL
    |=> cfg_r.spread_recalibration_interval == $past(wdata[7:6]))
    else $error("recalibration interval write not taken");

  unlocked_quiet_a: assert property (
    !link_locked |=> !recal_pulse_r)
    else $error("calibration request while unlocked");

  sawtooth_divider_write_a: assert property (
    wr && !cfg_r.config_lock_bit && addr == SLCFG_OFS_CAL |=> cfg_r.sawtooth_divider == $past(wdata[5:0]))
    else $error("sawtooth divider write not taken");

  sawtooth_divider_read_a: assert property (
    rd && addr == SLCFG_OFS_CAL |=> rdata_r[5:0] == $past(cfg_r.sawtooth_divider))
    else $error("sawtooth divider readback wrong");

  locked_write_c: cover property (wr && cfg_r.config_lock_bit);
  lock_pulse_c:   cover property (link_locked && !lock_d_r ##1 recal_pulse_r);
  periodic_c:     cover property (recal_pulse_r && lock_d_r && $past(lock_d_r));
  manual_sawtooth_divider_c:  cover property ($rose(sawtooth_divider_manual_r));
  strap_low_c:    cover property ($rose(strap_done_r) && cfg_r.spread == SLCFG_SPREAD_LOW);

endmodule // slcfg_regs

//--- verif/serializer_link_config_registers_test.sv
module serializer_link_config_registers_test import slcfg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // design under test
  // ****************************************************************
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [1:0]        configuration_pins = 2'h1;
  logic              link_locked = 1'b0;
  logic [7:0]        rdata_r;
  slcfg_cfg_t        cfg_r;
  logic              spread_on_r;
  logic              sawtooth_divider_manual_r;
  logic              recal_pulse_r;
  logic [7:0]        exp_r [4];
  int                n_mismatch = 0;
  int                total_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  // short recalibration periods keep the run brief; the per table in the tests repeats them
  slcfg_regs #(.RECAL_A_CYC(4), .RECAL_B_CYC(8), .RECAL_C_CYC(16)) uut (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .configuration_pins(configuration_pins), .link_locked(link_locked), .rdata_r(rdata_r),
    .cfg_r(cfg_r), .spread_on_r(spread_on_r), .sawtooth_divider_manual_r(sawtooth_divider_manual_r), .recal_pulse_r(recal_pulse_r));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // what a register holds after a taken write; the reserved bit never sticks
  function automatic logic [7:0] model_write(input logic [7:0] a, input logic [7:0] d);
    return (a == 8'h01) ? (d & 8'hFE) : d;
  endfunction

  // codes 000 and 100 are the two no-spread settings
  function automatic logic spread_expected(input logic [2:0] code);
    return code != 3'h0 && code != 3'h4;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
    #1;
    // locked bank and unmapped places leave the model alone
    if (exp_r[0][0] === 1'b0 && a < 8'h04) exp_r[a[1:0]] = model_write(a, d);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    v = rdata_r;
  endtask

  task automatic check_all();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'(i), v);
      check(v, exp_r[i]);
    end
    check(cfg_r, {exp_r[0], exp_r[1][7:1], exp_r[2], exp_r[3]});
    check(spread_on_r, spread_expected(exp_r[2][7:5]));
    check(sawtooth_divider_manual_r, exp_r[3][5:0] != 6'h00);
  endtask

  task automatic do_reset(input logic [1:0] pins);
    configuration_pins <= pins;
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    exp_r = '{8'h80, 8'h90, {2'b00, pins[0], 5'h1F}, 8'h00};
  endtask

  task automatic recal(input logic [1:0] iv, input int per);
    int n;
    int g;
    logic found;
    wr_reg(8'h03, {iv, 6'h05});
    link_locked <= 1'b1;
    found = 1'b0;
    for (n = 0; n < 6 && !found; n++) begin
      @(posedge ref_clk);
      #1;
      found = (recal_pulse_r === 1'b1);
    end
    check(found, 1'b1);
    g = 0;
    do begin
      @(posedge ref_clk);
      #1;
      g++;
    end while (recal_pulse_r !== 1'b1 && g < 40);
    check(g, (iv == 2'h0) ? 40 : per);
    link_locked <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(recal_pulse_r, 1'b0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    logic [7:0] v;
    int         per [4];
    per = '{0, 4, 8, 16};
    void'($urandom(32'h6246));
    do_reset(2'h1);
    check_all();
    $display("test reset_values done");
    // every spread code, with both divider extremes among random fill
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'h00, {7'($urandom), 1'b0});
      wr_reg(8'h01, 8'($urandom) | 8'h01);
      wr_reg(8'h02, {3'(s), 5'($urandom)});
      wr_reg(8'h03, (s == 0) ? 8'h00 : (s == 7) ? 8'hFF : 8'($urandom));
      check_all();
    end
    $display("test field_writes done");
    wr_reg(8'h10, 8'hFF);
    wr_reg(8'hA4, 8'h5A);
    rd_reg(8'h10, v);
    check(v, 8'h00);
    rd_reg(8'hFF, v);
    check(v, 8'h00);
    check_all();
    $display("test unmapped done");
    for (int i = 0; i < 4; i++) recal(2'(i), per[i]);
    $display("test recalibration done");
    wr_reg(8'h00, {7'h2A, 1'b1});
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h02, 8'($urandom));
    wr_reg(8'h03, 8'h3F);
    wr_reg(8'h01, 8'h22);
    check_all();
    // only a reset clears the lock; this strap picks no spread
    do_reset(2'h2);
    check_all();
    $display("test lock done");
    wrap_up();
  end

  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
endmodule // serializer_link_config_registers_test
